// *** stsq_defs.svh ***
// stsq_defs.svh: offsets, field positions, reset values and timing counts of the sequencer
// assumes: included by bare name wherever these constants are needed
`ifndef STSQ_DEFS_SVH
`define STSQ_DEFS_SVH

// timing base
`define STSQ_CLK_HZ 20000000
`define STSQ_OSC_HZ 18641
`define STSQ_OSC_CYC (`STSQ_CLK_HZ / `STSQ_OSC_HZ)
`define STSQ_START_MS 25
`define STSQ_PWR_MS 50
`define STSQ_CONV_MS 2
`define STSQ_START_CYC (`STSQ_START_MS * (`STSQ_CLK_HZ / 1000))
`define STSQ_PWR_CYC (`STSQ_PWR_MS * (`STSQ_CLK_HZ / 1000))
`define STSQ_CONV_CYC (`STSQ_CONV_MS * (`STSQ_CLK_HZ / 1000))

// divider chain shape
`define STSQ_STAGE_W 14
`define STSQ_FIRST_TAP 22
`define STSQ_LAST_TAP 28
`define STSQ_DIV_RST 28'h0000000

// address counter shape
`define STSQ_ADDR_W 12
`define STSQ_MEM_DEPTH 2048

// register byte offsets
`define STSQ_REG_CTRL 5'h00
`define STSQ_REG_STATUS 5'h04
`define STSQ_REG_RESULT 5'h08
`define STSQ_REG_IRQ_STAT 5'h0C
`define STSQ_REG_IRQ_MASK 5'h10
`define STSQ_REG_MEM_PTR 5'h14
`define STSQ_REG_MEM_DATA 5'h18

// control fields and reset value
`define STSQ_CTRL_TAP_LSB 0
`define STSQ_CTRL_TAP_MSB 2
`define STSQ_CTRL_OE_BIT 3
`define STSQ_CTRL_RUN_BIT 4
`define STSQ_CTRL_RST 5'h13

// interrupt bits
`define STSQ_IRQ_STORED 0
`define STSQ_IRQ_FULL 1
`define STSQ_IRQ_W 2

`endif

// *** stsq_pkg.sv ***
// stsq_pkg: state types shared by the sequencer and its converter
// assumes: compiled before every module that imports it
package stsq_pkg;
  typedef enum logic [0:0] {
    STSQ_CV_IDLE = 1'b0,
    STSQ_CV_RUN = 1'b1
  } stsq_conv_state_t;

  typedef enum logic [1:0] {
    STSQ_SQ_IDLE = 2'b00,
    STSQ_SQ_REC = 2'b01,
    STSQ_SQ_FULL = 2'b10
  } stsq_seq_state_t;
endpackage : stsq_pkg

// *** stsq_conv.sv ***
// stsq_conv: integrating 8-bit converter with latched three-state result
// assumes: single clock, level input already synchronised by the caller
`include "stsq_defs.svh"

module stsq_conv
  import stsq_pkg::*;
#(
  parameter int CONV_CYC = `STSQ_CONV_CYC
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic pwr_in,
  input wire logic start_in,
  input wire logic [7:0] level_in,
  input wire logic oe_in,
  output logic [7:0] result_out,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic eoc_out,
  output logic busy_out
);
  stsq_conv_state_t state_r;
  logic [31:0] step_r;
  logic [7:0] cap_r;
  logic [7:0] pulse_r;
  logic last_step;

  assign last_step = (step_r == CONV_CYC - 1);

  // conversion cycle: once begun it cannot be cut short while powered
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r <= STSQ_CV_IDLE;
      step_r <= '0;
      cap_r <= 8'h00;
    end else if (!pwr_in) begin
      state_r <= STSQ_CV_IDLE; // unpowered converter loses the cycle
      step_r <= '0;
    end else if (state_r == STSQ_CV_IDLE) begin
      if (start_in) begin
        state_r <= STSQ_CV_RUN;
        step_r <= '0;
        cap_r <= level_in;
      end
    end else if (last_step) begin
      step_r <= '0;
      cap_r <= level_in;
      if (!start_in) begin
        state_r <= STSQ_CV_IDLE;
      end
    end else begin
      step_r <= step_r + 32'd1;
    end
  end

  // reference pulse count balancing the captured level; full scale is all ones
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pulse_r <= 8'h00;
    end else if (state_r != STSQ_CV_RUN || last_step || !pwr_in) begin
      pulse_r <= 8'h00;
    end else if (pulse_r < cap_r) begin
      pulse_r <= pulse_r + 8'h01;
    end
  end

  // latch and end-of-conversion; start held high free-runs
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      result_out <= 8'h00;
      eoc_out <= 1'b0;
    end else begin
      eoc_out <= 1'b0;
      if (pwr_in && state_r == STSQ_CV_RUN && last_step) begin
        result_out <= (pulse_r < cap_r) ? pulse_r + 8'h01 : pulse_r;
        eoc_out <= 1'b1;
      end
    end
  end

  // three-state output pins, driven only when enabled
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      data_oe_out <= oe_in;
      data_out <= oe_in ? result_out : 8'h00;
      busy_out <= (state_r == STSQ_CV_RUN);
    end
  end
endmodule : stsq_conv

// *** stsq_top.sv ***
// stsq_top: sample timer, recording sequencer, converter control and address counter
// assumes: one 20 MHz clock, synchronous reset, Avalon-MM slave on the register side
//
// Function
// - divider chain cascades binary stages, up to 28, first counter clocks second
// - first group is a 14-bit counter fed by the oscillator, feeding next
// - oscillator nominal 18.641 kHz is the reference for all sampling periods
// - sampling tick comes from one selectable stage, 22 through 28
// - selectable stages give intervals doubling from 3.75 to 240 minutes
// - each tick powers sensor path, converts, stores result, advances the address
// - a started conversion runs to completion and latches before stopping
// - start held high free-runs the converter, refreshing every 2 ms
// - after start falls the running conversion still completes while powered
// - converter data outputs are three-state for bus sharing
// - result is 8-bit unsigned, all ones top, all zeros bottom
// - converter counts reference pulses and latches that count
// - end of conversion resets input circuitry and flags completion
// - 12-stage address counter, low 11 bits address 2048 locations
// - address stage 12 is the memory-full indication
// - start-convert window lasts 25 ms from each tick
// - address advances at trailing edge of the 50 ms power window
// - memory full stops the oscillator and holds both dividers at zero
`include "stsq_defs.svh"

module stsq_top
  import stsq_pkg::*;
#(
  parameter int OSC_CYC = `STSQ_OSC_CYC,
  parameter int START_CYC = `STSQ_START_CYC,
  parameter int PWR_CYC = `STSQ_PWR_CYC,
  parameter int CONV_CYC = `STSQ_CONV_CYC,
  parameter logic [2*`STSQ_STAGE_W-1:0] DIV_RST = `STSQ_DIV_RST
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic [7:0] sensor_level_in,
  output logic sensor_pwr_out,
  output logic start_conv_out,
  output logic [7:0] adc_data_out,
  output logic adc_data_oe_out,
  output logic mem_full_out,
  output logic sample_tick_out
);
  localparam int TAP_SPAN = `STSQ_LAST_TAP - `STSQ_FIRST_TAP;

  // synchroniser for the analog level pins
  logic [7:0] lvl_s1_r;
  logic [7:0] lvl_s2_r;
  logic [7:0] lvl_s3_r;
  logic [7:0] lvl_r;

  // divider chain
  logic [31:0] osc_cnt_r;
  logic osc_tick;
  logic [`STSQ_STAGE_W-1:0] div_lo_r;
  logic [`STSQ_STAGE_W-1:0] div_hi_r;
  logic [2*`STSQ_STAGE_W-1:0] stages;
  logic [2:0] tap_act_r;
  logic tap_bit;
  logic tap_prev_r;
  logic tick;

  // recording sequence
  stsq_seq_state_t seq_r;
  logic [31:0] win_r;
  logic win_end;
  logic [`STSQ_ADDR_W-1:0] addr_r;
  logic [7:0] mem_r [0:`STSQ_MEM_DEPTH-1];
  logic [7:0] conv_result;
  logic conv_eoc;
  logic conv_busy;

  // registers
  logic [4:0] ctrl_r;
  logic [`STSQ_IRQ_W-1:0] irq_stat_r;
  logic [`STSQ_IRQ_W-1:0] irq_mask_r;
  logic [10:0] mem_ptr_r;
  logic [7:0] mem_rd_r;
  logic [`STSQ_IRQ_W-1:0] irq_evt;
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic [31:0] rd_nxt;
  logic run_en;
  logic full;

  assign run_en = ctrl_r[`STSQ_CTRL_RUN_BIT];
  assign full = addr_r[`STSQ_ADDR_W-1];
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_take = bus_req & ~avs_waitrequest_out;
  assign wr_take = avs_write_in & ~avs_waitrequest_out;

  // three flops; a change is accepted only once stages two and three agree
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      lvl_s1_r <= 8'h00;
      lvl_s2_r <= 8'h00;
      lvl_s3_r <= 8'h00;
      lvl_r <= 8'h00;
    end else begin
      lvl_s1_r <= sensor_level_in;
      lvl_s2_r <= lvl_s1_r;
      lvl_s3_r <= lvl_s2_r;
      if (lvl_s2_r == lvl_s3_r) begin
        lvl_r <= lvl_s3_r;
      end
    end
  end

  // oscillator: nominal crystal rate derived from the core clock
  always_ff @(posedge core_clk_in) begin
    if (srst_in || full || !run_en) begin
      osc_cnt_r <= '0;
    end else if (osc_cnt_r == OSC_CYC - 1) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 32'd1;
    end
  end

  assign osc_tick = (osc_cnt_r == OSC_CYC - 1) && run_en && !full;

  // first 14-stage counter, clocked by the oscillator
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_lo_r <= DIV_RST[`STSQ_STAGE_W-1:0]; // start point, zero unless a test seeds it
    end else if (full) begin
      div_lo_r <= '0;
    end else if (osc_tick) begin
      div_lo_r <= div_lo_r + 1'b1;
    end
  end

  // second counter, clocked by the first one's final stage falling
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_hi_r <= DIV_RST[2*`STSQ_STAGE_W-1:`STSQ_STAGE_W];
    end else if (full) begin
      div_hi_r <= '0;
    end else if (osc_tick && (&div_lo_r)) begin
      div_hi_r <= div_hi_r + 1'b1;
    end
  end

  // stage n of the chain is bit n-1; 28 stages at most
  assign stages = {div_hi_r, div_lo_r};

  // tap selection picks stage 22 + index; values above the span clamp to 28
  always_comb begin
    if (tap_act_r > 3'(TAP_SPAN)) begin
      tap_bit = stages[`STSQ_LAST_TAP-1];
    end else begin
      tap_bit = stages[`STSQ_FIRST_TAP - 1 + int'(tap_act_r)];
    end
  end

  // tap index follows the control field only between recordings
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tap_act_r <= 3'(`STSQ_CTRL_RST);
    end else if (seq_r == STSQ_SQ_IDLE) begin
      tap_act_r <= ctrl_r[`STSQ_CTRL_TAP_MSB:`STSQ_CTRL_TAP_LSB];
    end
  end

  // trailing edge of the chosen stage, as the counters advance on falls
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tap_prev_r <= 1'b0;
    end else begin
      tap_prev_r <= tap_bit;
    end
  end

  assign tick = tap_prev_r & ~tap_bit;

  // recording sequence: idle, one power window per tick, full stops it all
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      seq_r <= STSQ_SQ_IDLE;
    end else begin
      case (seq_r)
        STSQ_SQ_IDLE: begin
          if (full) begin
            seq_r <= STSQ_SQ_FULL;
          end else if (tick) begin
            seq_r <= STSQ_SQ_REC;
          end
        end
        STSQ_SQ_REC: begin
          if (win_end) begin
            seq_r <= STSQ_SQ_IDLE;
          end
        end
        STSQ_SQ_FULL: begin
          seq_r <= STSQ_SQ_FULL;
        end
        default: begin
          seq_r <= STSQ_SQ_IDLE;
        end
      endcase
    end
  end

  // window timer shared by the start and power pulses
  always_ff @(posedge core_clk_in) begin
    if (srst_in || seq_r != STSQ_SQ_REC) begin
      win_r <= '0;
    end else if (!win_end) begin
      win_r <= win_r + 32'd1;
    end
  end

  assign win_end = (seq_r == STSQ_SQ_REC) && (win_r == PWR_CYC - 1);

  // power and start pulses; power outlasts start so the last conversion lands
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sensor_pwr_out <= 1'b0;
      start_conv_out <= 1'b0;
      sample_tick_out <= 1'b0;
    end else begin
      sample_tick_out <= tick && seq_r == STSQ_SQ_IDLE && !full;
      if (seq_r == STSQ_SQ_IDLE && tick && !full) begin
        sensor_pwr_out <= 1'b1;
        start_conv_out <= 1'b1;
      end else begin
        if (win_end) begin
          sensor_pwr_out <= 1'b0;
        end
        if (win_r == START_CYC - 1) begin
          start_conv_out <= 1'b0;
        end
      end
    end
  end

  // address counter steps on the trailing edge of the power window
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      addr_r <= '0;
    end else if (win_end && !full) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  // each end of conversion overwrites the current location; the last one stays
  always_ff @(posedge core_clk_in) begin
    if (conv_eoc && sensor_pwr_out && !full) begin
      mem_r[addr_r[`STSQ_ADDR_W-2:0]] <= conv_result;
    end
  end

  // read port for software, one cycle behind the pointer
  always_ff @(posedge core_clk_in) begin
    mem_rd_r <= mem_r[mem_ptr_r];
  end

  stsq_conv #(
    .CONV_CYC(CONV_CYC)
  ) u_conv (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .pwr_in(sensor_pwr_out),
    .start_in(start_conv_out),
    .level_in(lvl_r),
    .oe_in(ctrl_r[`STSQ_CTRL_OE_BIT]),
    .result_out(conv_result),
    .data_out(adc_data_out),
    .data_oe_out(adc_data_oe_out),
    .eoc_out(conv_eoc),
    .busy_out(conv_busy)
  );

  // memory-full flag straight from the counter's top stage
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mem_full_out <= 1'b0;
    end else begin
      mem_full_out <= full;
    end
  end

  // waitrequest drops for one cycle per request, readdata ready in that cycle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rd_nxt;
      end
    end
  end

  // read decode; unmapped offsets read as zero
  always_comb begin
    rd_nxt = 32'h00000000;
    case (avs_address_in)
      `STSQ_REG_CTRL: rd_nxt = {27'h0000000, ctrl_r};
      `STSQ_REG_STATUS: rd_nxt = {14'h0000, seq_r, conv_busy, full, 2'h0, addr_r};
      `STSQ_REG_RESULT: rd_nxt = {24'h000000, conv_result};
      `STSQ_REG_IRQ_STAT: rd_nxt = {30'h00000000, irq_stat_r};
      `STSQ_REG_IRQ_MASK: rd_nxt = {30'h00000000, irq_mask_r};
      `STSQ_REG_MEM_PTR: rd_nxt = {21'h000000, mem_ptr_r};
      `STSQ_REG_MEM_DATA: rd_nxt = {24'h000000, mem_rd_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // control, mask and pointer writes take effect when waitrequest is low
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctrl_r <= `STSQ_CTRL_RST;
      irq_mask_r <= '0;
      mem_ptr_r <= '0;
    end else if (wr_take) begin
      case (avs_address_in)
        `STSQ_REG_CTRL: ctrl_r <= avs_writedata_in[4:0];
        `STSQ_REG_IRQ_MASK: irq_mask_r <= avs_writedata_in[`STSQ_IRQ_W-1:0];
        `STSQ_REG_MEM_PTR: mem_ptr_r <= avs_writedata_in[10:0];
        default: mem_ptr_r <= mem_ptr_r;
      endcase
    end
  end

  // events: a sample stored at window end, and the memory reaching full
  assign irq_evt[`STSQ_IRQ_STORED] = win_end;
  assign irq_evt[`STSQ_IRQ_FULL] = full & ~mem_full_out;

  // sticky status, write one to clear; an event in the clear cycle wins
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      irq_stat_r <= '0;
    end else if (wr_take && avs_address_in == `STSQ_REG_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~avs_writedata_in[`STSQ_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // level interrupt, registered, so it trails the status bit by a cycle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  // bus_take is kept for readability of the handshake; reads have no side effects
  logic unused_take;
  assign unused_take = bus_take;
endmodule : stsq_top

// *** stsq_sensor_model.sv ***
// stsq_sensor_model: sensor front end and the shared data line
// assumes: bench clock; level_set_in held steady per sample
module stsq_sensor_model (
  input wire logic core_clk_in,
  input wire logic pwr_in,
  input wire logic [7:0] level_set_in,
  input wire logic [7:0] adc_data_in,
  input wire logic adc_oe_in,
  output logic [7:0] level_out,
  output logic [7:0] bus_out
);
  logic [7:0] junk_r = 8'h5A;
  // toggling filler, so a stale value never passes for a real one
  always_ff @(posedge core_clk_in) begin
    junk_r <= ~junk_r;
  end
  // unpowered front end gives no valid level
  assign level_out = pwr_in ? level_set_in : junk_r;
  // another driver owns the line once the converter lets go
  assign bus_out = adc_oe_in ? adc_data_in : junk_r;
endmodule : stsq_sensor_model

// *** stsq_top_checker.sv ***
// stsq_top_checker: timing relations of the recording windows
// assumes: bound into stsq_top, one clock, synchronous reset
module stsq_top_checker #(
  parameter int START_CYC = 500000,
  parameter int PWR_CYC = 1000000
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic sensor_pwr_out,
  input wire logic start_conv_out,
  input wire logic [7:0] adc_data_out,
  input wire logic adc_data_oe_out,
  input wire logic mem_full_out,
  input wire logic sample_tick_out
);
  logic [31:0] start_cnt_r;
  logic [31:0] pwr_cnt_r;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // window lengths far exceed a repetition count, so count them
  always_ff @(posedge core_clk_in) begin
    if (srst_in || !start_conv_out) begin
      start_cnt_r <= '0;
    end else begin
      start_cnt_r <= start_cnt_r + 32'h1;
    end
  end
  // power window length
  always_ff @(posedge core_clk_in) begin
    if (srst_in || !sensor_pwr_out) begin
      pwr_cnt_r <= '0;
    end else begin
      pwr_cnt_r <= pwr_cnt_r + 32'h1;
    end
  end
  property p_tick_rise;
    sample_tick_out |-> $rose(sensor_pwr_out) && $rose(start_conv_out);
  endproperty
  a_tick_rise: assert property (p_tick_rise)
    else $error("windows did not open after tick");
  property p_start_len;
    $fell(start_conv_out) |-> start_cnt_r == START_CYC;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start window length wrong");
  property p_pwr_len;
    $fell(sensor_pwr_out) |-> pwr_cnt_r == PWR_CYC;
  endproperty
  a_pwr_len: assert property (p_pwr_len)
    else $error("power window length wrong");
  property p_start_in_pwr;
    start_conv_out |-> sensor_pwr_out;
  endproperty
  a_start_in_pwr: assert property (p_start_in_pwr)
    else $error("start outside power window");
  property p_tick_idle;
    $past(sensor_pwr_out) |-> !sample_tick_out;
  endproperty
  a_tick_idle: assert property (p_tick_idle)
    else $error("tick accepted while recording");
  property p_full_hold;
    mem_full_out |=> mem_full_out;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full flag dropped");
  property p_full_quiet;
    mem_full_out |-> !sample_tick_out;
  endproperty
  a_full_quiet: assert property (p_full_quiet)
    else $error("tick while full");
  property p_oe_off;
    !adc_data_oe_out |-> adc_data_out == 8'h00;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data driven while disabled");
endmodule : stsq_top_checker

bind stsq_top stsq_top_checker #(.START_CYC(START_CYC), .PWR_CYC(PWR_CYC)) u_chk (
  .core_clk_in(core_clk_in),
  .srst_in(srst_in),
  .sensor_pwr_out(sensor_pwr_out),
  .start_conv_out(start_conv_out),
  .adc_data_out(adc_data_out),
  .adc_data_oe_out(adc_data_oe_out),
  .mem_full_out(mem_full_out),
  .sample_tick_out(sample_tick_out)
);

// *** tb_sample_timer_adc_address_sequencer.sv ***
// tb: register access and one full recording at the fastest tap
// assumes: design, model and checker compiled first; divider seeded so the first tick comes early
`include "stsq_defs.svh"

module tb_sample_timer_adc_address_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int START_CYC = 700;
  localparam int PWR_CYC = 1000;
  localparam int CONV_CYC = 300;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, irq_out, sensor_pwr_out, start_conv_out;
  logic adc_data_oe_out, mem_full_out, sample_tick_out;
  logic [7:0] adc_data_out, sensor_level, shared_bus;
  logic [7:0] level_set = 8'hC3;
  logic [31:0] rd;
  int fails = 0;
  int checks = 0;
  int st_cnt = 0;
  int pw_cnt = 0;
  int n;

  always #25 core_clk_in = ~core_clk_in;

  // conversion longer than full scale counts; seed puts the stage-22 fall 1536 cycles out
  stsq_top #(.OSC_CYC(1), .START_CYC(START_CYC), .PWR_CYC(PWR_CYC), .CONV_CYC(CONV_CYC),
    .DIV_RST(28'h03FFA00)) u_dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .irq_out(irq_out), .sensor_level_in(sensor_level),
    .sensor_pwr_out(sensor_pwr_out), .start_conv_out(start_conv_out),
    .adc_data_out(adc_data_out), .adc_data_oe_out(adc_data_oe_out),
    .mem_full_out(mem_full_out), .sample_tick_out(sample_tick_out)
  );

  stsq_sensor_model u_model (
    .core_clk_in(core_clk_in), .pwr_in(sensor_pwr_out), .level_set_in(level_set),
    .adc_data_in(adc_data_out), .adc_oe_in(adc_data_oe_out),
    .level_out(sensor_level), .bus_out(shared_bus)
  );

  // window lengths seen at the pins
  always @(posedge core_clk_in) begin
    if (start_conv_out === 1'b1) st_cnt++;
    if (sensor_pwr_out === 1'b1) pw_cnt++;
  end

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_pin(input logic got, input logic exp, input string what);
    cmp_word({31'h0, got}, {31'h0, exp}, what);
  endtask : cmp_pin

  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (k >= 50) begin
      fails++;
      $display("MISMATCH t=%0t bus hung", $time);
    end
  endtask : bus_xfer

  task automatic reg_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus_xfer(1'b0, a, 32'h0);
    cmp_word(rd, exp, what);
  endtask : reg_chk

  // watchdog: seeded first tick, one window and register traffic, plus margin
  initial begin
    repeat (10000) @(posedge core_clk_in);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (20) @(posedge core_clk_in);
    srst_in <= 1'b0;
    // reset values and an unmapped hole
    reg_chk(`STSQ_REG_CTRL, 32'h13, "ctrl reset");
    reg_chk(`STSQ_REG_STATUS, 32'h0, "status reset");
    reg_chk(`STSQ_REG_IRQ_STAT, 32'h0, "irq reset");
    reg_chk(5'h1C, 32'h0, "unmapped");
    // fastest tap, outputs on, window irq unmasked
    bus_xfer(1'b1, `STSQ_REG_CTRL, 32'h18);
    reg_chk(`STSQ_REG_CTRL, 32'h18, "ctrl rw");
    bus_xfer(1'b1, `STSQ_REG_IRQ_MASK, 32'h1);
    cmp_pin(adc_data_oe_out, 1'b1, "oe on");
    n = 0;
    while (sample_tick_out !== 1'b1 && n < 4000) begin
      @(posedge core_clk_in);
      n++;
    end
    cmp_pin(sample_tick_out, 1'b1, "tick seen");
    @(posedge core_clk_in);
    cmp_pin(sensor_pwr_out, 1'b1, "power up");
    cmp_pin(start_conv_out, 1'b1, "start up");
    bus_xfer(1'b0, `STSQ_REG_STATUS, 32'h0);
    cmp_word({30'h0, rd[17:16]}, 32'h1, "recording");
    n = 0;
    while (sensor_pwr_out !== 1'b0 && n < 2 * PWR_CYC) begin
      @(posedge core_clk_in);
      n++;
    end
    cmp_word(st_cnt, START_CYC, "start len");
    cmp_word(pw_cnt, PWR_CYC, "power len");
    repeat (3) @(posedge core_clk_in);
    cmp_pin(irq_out, 1'b1, "window irq");
    bus_xfer(1'b0, `STSQ_REG_STATUS, 32'h0);
    cmp_word(rd & 32'h0000CFFF, 32'h1, "addr advanced");
    cmp_pin(mem_full_out, 1'b0, "not full");
    reg_chk(`STSQ_REG_RESULT, 32'hC3, "result");
    cmp_word({24'h0, shared_bus}, 32'hC3, "bus data");
    bus_xfer(1'b1, `STSQ_REG_MEM_PTR, 32'h0);
    reg_chk(`STSQ_REG_MEM_DATA, 32'hC3, "stored");
    // masking hides the sticky bit, clearing drops it
    bus_xfer(1'b1, `STSQ_REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk_in);
    cmp_pin(irq_out, 1'b0, "masked");
    reg_chk(`STSQ_REG_IRQ_STAT, 32'h1, "sticky");
    bus_xfer(1'b1, `STSQ_REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk_in);
    cmp_pin(irq_out, 1'b1, "unmasked");
    bus_xfer(1'b1, `STSQ_REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk_in);
    cmp_pin(irq_out, 1'b0, "cleared");
    reg_chk(`STSQ_REG_IRQ_STAT, 32'h0, "stat clear");
    // release the data line
    bus_xfer(1'b1, `STSQ_REG_CTRL, 32'h10);
    repeat (2) @(posedge core_clk_in);
    cmp_pin(adc_data_oe_out, 1'b0, "oe off");
    cmp_word({24'h0, adc_data_out}, 32'h0, "data off");
    close_out();
  end
endmodule : tb_sample_timer_adc_address_sequencer
